// file: hw/hra_pkg.sv
// Purpose: shared constants and types of the remote activation controller
// Assumes: 50 MHz ref_clk, 1 ms timebase tick
// Notes:   timer figures are in milliseconds
package hra_pkg;
   // clock and timebase
   localparam int unsigned CLK_PERIOD_NS = 20;
   localparam int unsigned TICK_PERIOD_NS = 1000000;
   localparam int unsigned TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // timer terminal counts, ms
   localparam logic [14:0] PRE_WAIT_MS = 15'h07d0;   // 2000 ms
   localparam logic [14:0] RESPONSE_MS = 15'h0fa0;   // 4000 ms bound
   localparam logic [14:0] SETTLE_MS   = 15'h0fa0;   // 4000 ms bound
   localparam logic [14:0] ACT_MS      = 15'h7148;   // 29000 ms
   localparam logic [14:0] PEND_MS     = 15'h07d0;   // 2000 ms
   // frame counts
   localparam logic [2:0] SYNC_MISS_MAX = 3'h6;
   localparam logic [2:0] READY_ZEROS   = 3'h6;
   localparam logic [2:0] STUFF_RUN_MAX = 3'h4;
   // register map, byte addresses
   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam int CTRL_QUIET = 0;
   localparam int ST_SYNC_LOST = 4;
   localparam int ST_TIMEOUT = 5;
   localparam int ST_LINE_ABSENT = 6;
   localparam int ST_LOCAL_READY = 7;
   localparam int ST_FAR_READY = 8;
   localparam int ST_SETTLED = 9;
   localparam int ST_LATE = 10;
   localparam logic CTRL_RESET = 1'b0;
   // scrambler taps, 23-bit register
   localparam int SCR_TAP_A = 4;
   localparam int SCR_TAP_B = 22;
   localparam logic [22:0] SCR_SEED = 23'h000001;

   typedef enum logic [3:0] {
      ST_INACTIVE = 4'b0000,
      ST_PRE_WAIT = 4'b0001,
      ST_WAKEUP   = 4'b0010,
      ST_TRAINING = 4'b0011,
      ST_ACT_RX   = 4'b0100,
      ST_ACT_TX   = 4'b0101,
      ST_ACT_TXRX = 4'b0110,
      ST_PENDING  = 4'b0111,
      ST_DEACT    = 4'b1000
   } hra_state_t;

   typedef enum logic [1:0] {
      SLOT_SYNC    = 2'b00,
      SLOT_STUFF   = 2'b01,
      SLOT_OVHD    = 2'b10,
      SLOT_PAYLOAD = 2'b11
   } hra_slot_kind_t;

   // 2B1Q quat codes: sign bit then inverted magnitude
   localparam logic [1:0] LVL_P3 = 2'h2;
   localparam logic [1:0] LVL_M3 = 2'h0;

   typedef struct packed {
      logic           sym_en;
      logic           frame_start;
      hra_slot_kind_t kind;
      logic           ready_slot;
      logic [1:0]     bits;
   } hra_tx_slot_t;

   typedef struct packed {
      logic       frame_end;
      logic       sync_hit;
      logic       indc_bit;
      logic       four_level;
      logic       data_valid;
      logic [1:0] data;
   } hra_rx_t;
endpackage : hra_pkg

// file: hw/hra_remote_activation.sv
// Purpose: start-up state machine and line signal generator of the remote unit
// Assumes: framer supplies symbol slots, receiver supplies per-frame sync results
// Notes:   line_signal_absent arrives from a pin and is synchronised here
`timescale 1ns/1ps
module hra_remote_activation
   import hra_pkg::*;
#(
   parameter int unsigned TICK_CYC = TICK_CYCLES
)(
   // clock and reset
   input  wire logic         ref_clk,
   input  wire logic         sys_rst,
   // register port
   input  wire logic [3:0]   reg_addr,
   input  wire logic [31:0]  reg_wdata,
   input  wire logic         reg_wr,
   input  wire logic         reg_rd,
   output logic      [31:0]  reg_rdata,
   // line pin and receiver
   input  wire logic         line_signal_absent_pin,
   input  wire hra_rx_t      rx,
   output logic      [1:0]   rx_core_data,
   // transmitter
   input  wire hra_tx_slot_t tx_slot,
   input  wire logic [1:0]   tx_core_data,
   output logic      [1:0]   tx_level,
   output logic              tx_on,
   // status
   output hra_state_t        state,
   output logic              frame_sync_lost,
   output logic              sync_loss_timeout
);
   logic        absent_meta;
   logic        line_signal_absent;
   logic        quiet;
   logic [15:0] tick_cnt;
   logic        tick;
   logic [14:0] step_ms;
   logic [14:0] act_ms;
   logic        act_run;
   logic [14:0] settle_ms;
   logic        settle_run;
   logic        timing_settled;
   logic [14:0] resp_ms;
   logic        resp_run;
   logic        response_late;
   logic        hit_once;
   logic [2:0]  miss_cnt;
   logic [2:0]  zero_cnt;
   logic        far_ready;
   logic        local_ready;
   logic        act_expired;
   logic        step_done;
   logic [22:0] scr;
   logic        stuff_pol;
   logic        next_stuff_pol;
   logic [2:0]  stuff_run;
   logic        ready_bit;
   hra_state_t  next_state;

   function automatic logic [23:0] scramble(input logic [22:0] sr, input logic d);
      logic s;
      s = d ^ sr[SCR_TAP_A] ^ sr[SCR_TAP_B];
      return {s, sr[21:0], s};
   endfunction : scramble

   // line signal pin synchroniser
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         absent_meta        <= 1'b1;
         line_signal_absent <= 1'b1;
      end
      else
      begin
         absent_meta        <= line_signal_absent_pin;
         line_signal_absent <= absent_meta;
      end
   end

   // millisecond timebase
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst || tick)
         tick_cnt <= 16'h0000;
      else
         tick_cnt <= tick_cnt + 16'h0001;
   end
   assign tick = (tick_cnt == 16'(TICK_CYC - 1));

   // frame sync search
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         frame_sync_lost <= 1'b1;
         hit_once        <= 1'b0;
         miss_cnt        <= 3'h0;
      end
      else if (rx.frame_end)
      begin
         if (frame_sync_lost)
         begin
            hit_once <= rx.sync_hit && !hit_once;
            if (rx.sync_hit && hit_once)
            begin
               frame_sync_lost <= 1'b0;
               miss_cnt        <= 3'h0;
            end
         end
         else if (rx.sync_hit)
            miss_cnt <= 3'h0;
         else if (miss_cnt == SYNC_MISS_MAX - 3'h1)
         begin
            frame_sync_lost <= 1'b1;
            hit_once        <= 1'b0;
            miss_cnt        <= 3'h0;
         end
         else
            miss_cnt <= miss_cnt + 3'h1;
      end
   end

   // far readiness from the received overhead bit
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst || state == ST_INACTIVE || state == ST_DEACT)
      begin
         zero_cnt  <= 3'h0;
         far_ready <= 1'b0;
      end
      else if (rx.frame_end && !frame_sync_lost)
      begin
         if (rx.indc_bit)
            zero_cnt <= 3'h0;
         else if (zero_cnt != READY_ZEROS)
            zero_cnt <= zero_cnt + 3'h1;
         if (!rx.indc_bit && zero_cnt == READY_ZEROS - 3'h1)
            far_ready <= 1'b1;
      end
   end

   assign local_ready = !frame_sync_lost && state != ST_INACTIVE && state != ST_PRE_WAIT
                        && state != ST_WAKEUP && state != ST_DEACT;
   assign act_expired = act_run && act_ms == ACT_MS;
   assign step_done = (state == ST_PRE_WAIT && step_ms == PRE_WAIT_MS)
                      || (state == ST_PENDING && step_ms == PEND_MS);

   // state step timer: pre-wake-up wait and pending deactivation
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst || next_state != state)
         step_ms <= 15'h0000;
      else if (tick && !step_done)
         step_ms <= step_ms + 15'h0001;
   end

   // activation timer, paused while the training reply is pending
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst || next_state == ST_INACTIVE || next_state == ST_DEACT)
      begin
         act_ms  <= 15'h0000;
         act_run <= 1'b0;
      end
      else if (state == ST_PRE_WAIT && next_state == ST_WAKEUP)
      begin
         act_ms  <= 15'h0000;
         act_run <= 1'b1;
      end
      else if (state == ST_WAKEUP && next_state == ST_TRAINING)
         act_run <= 1'b0;
      else if (state == ST_TRAINING && !act_run && !rx.four_level)
         act_run <= 1'b1;
      else if (act_run && tick && act_ms != ACT_MS)
         act_ms <= act_ms + 15'h0001;
   end

   // timing settle timer from the start of wake-up
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst || state == ST_INACTIVE)
      begin
         settle_ms      <= 15'h0000;
         settle_run     <= 1'b0;
         timing_settled <= 1'b0;
      end
      else if (state == ST_PRE_WAIT && next_state == ST_WAKEUP)
      begin
         settle_ms      <= 15'h0000;
         settle_run     <= 1'b1;
         timing_settled <= 1'b0;
      end
      else if (settle_run && tick)
      begin
         if (settle_ms == SETTLE_MS - 15'h0001)
         begin
            settle_run     <= 1'b0;
            timing_settled <= 1'b1;
         end
         settle_ms <= settle_ms + 15'h0001;
      end
   end

   // response timer: training goes out at once, late flag if limit met
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst || state == ST_INACTIVE)
      begin
         resp_ms       <= 15'h0000;
         resp_run      <= 1'b0;
         response_late <= 1'b0;
      end
      else if (state == ST_WAKEUP && next_state == ST_TRAINING)
      begin
         resp_ms  <= 15'h0000;
         resp_run <= 1'b1;
      end
      else if (resp_run && tx_on && state != ST_WAKEUP)
         resp_run <= 1'b0;
      else if (resp_run && tick)
      begin
         resp_ms <= resp_ms + 15'h0001;
         if (resp_ms == RESPONSE_MS - 15'h0001)
            response_late <= 1'b1;
      end
   end

   // activation state machine
   always_comb
   begin
      next_state = state;
      unique case (state)
         ST_INACTIVE: if (!line_signal_absent) next_state = ST_PRE_WAIT;
         ST_PRE_WAIT:
            if (line_signal_absent)
               next_state = ST_INACTIVE;
            else if (step_done)
               next_state = ST_WAKEUP;
         ST_WAKEUP:
            if (rx.four_level && !frame_sync_lost)
               next_state = ST_TRAINING;
            else if (act_expired)
               next_state = ST_DEACT;
         ST_TRAINING:
            if (!frame_sync_lost)
               next_state = ST_ACT_RX;
            else if (far_ready)
               next_state = ST_ACT_TX;
            else if (act_expired)
               next_state = ST_DEACT;
         ST_ACT_RX: if (far_ready || act_expired) next_state = ST_ACT_TXRX;
         ST_ACT_TX: if (local_ready || act_expired) next_state = ST_ACT_TXRX;
         ST_ACT_TXRX: if (frame_sync_lost) next_state = ST_PENDING;
         ST_PENDING:
            if (!frame_sync_lost)
               next_state = ST_ACT_TXRX;
            else if (step_done)
               next_state = ST_DEACT;
         ST_DEACT: if (line_signal_absent) next_state = ST_INACTIVE;
         default: next_state = ST_INACTIVE;
      endcase
      if (quiet && state != ST_INACTIVE)
         next_state = ST_DEACT;
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         state <= ST_INACTIVE;
      else
         state <= next_state;
   end

   // sync loss timeout flag, set wins over clear
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         sync_loss_timeout <= 1'b0;
      else if (state == ST_PENDING && next_state == ST_DEACT && !quiet)
         sync_loss_timeout <= 1'b1;
      else if (reg_wr && reg_addr == REG_STATUS && reg_wdata[ST_TIMEOUT])
         sync_loss_timeout <= 1'b0;
   end

   // line transmitter
   assign ready_bit = !local_ready;
   assign next_stuff_pol = !stuff_pol;
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         scr       <= SCR_SEED;
         stuff_pol <= 1'b0;
         stuff_run <= 3'h0;
         tx_level  <= LVL_M3;
         tx_on     <= 1'b0;
      end
      else if (tx_slot.sym_en)
      begin
         tx_on <= state inside {ST_WAKEUP, ST_TRAINING, ST_ACT_RX, ST_ACT_TX, ST_ACT_TXRX, ST_PENDING};
         if (tx_slot.frame_start)
         begin
            stuff_pol <= next_stuff_pol;
            stuff_run <= (next_stuff_pol == stuff_pol) ? stuff_run + 3'h1 : 3'h1;
         end
         unique case (tx_slot.kind)
            SLOT_SYNC: tx_level <= tx_slot.bits;
            SLOT_STUFF: tx_level <= stuff_pol ? LVL_P3 : LVL_M3;
            default:
            begin
               logic [23:0] a;
               logic [23:0] b;
               logic [1:0]  d;
               a = 24'h000000;
               b = 24'h000000;
               d = 2'h3;
               if (state == ST_ACT_TX || state == ST_ACT_TXRX || state == ST_PENDING)
                  d = (tx_slot.kind == SLOT_PAYLOAD && far_ready) ? tx_core_data : d;
               if (tx_slot.kind == SLOT_OVHD && state != ST_WAKEUP)
                  d = tx_slot.ready_slot ? {ready_bit, tx_slot.bits[0]} : tx_slot.bits;
               if (state == ST_WAKEUP)
                  d = 2'h3;
               a = scramble(scr, d[1]);
               b = scramble(a[22:0], d[0]);
               scr <= b[22:0];
               if (state == ST_WAKEUP)
                  tx_level <= a[23] ? LVL_P3 : LVL_M3;
               else
                  tx_level <= {a[23], b[23]};
            end
         endcase
      end
   end

   // receive data towards the core
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         rx_core_data <= 2'h3;
      else if (rx.data_valid)
         rx_core_data <= (state inside {ST_ACT_RX, ST_ACT_TXRX, ST_PENDING}) ? rx.data : 2'h3;
   end

   // register port
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         quiet <= CTRL_RESET;
      else if (reg_wr && reg_addr == REG_CTRL)
         quiet <= reg_wdata[CTRL_QUIET];
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst || !reg_rd)
         reg_rdata <= 32'h00000000;
      else if (reg_addr == REG_CTRL)
         reg_rdata <= {31'h00000000, quiet};
      else if (reg_addr == REG_STATUS)
         reg_rdata <= {21'h000000, response_late, timing_settled, far_ready, local_ready,
                       line_signal_absent, sync_loss_timeout, frame_sync_lost, state};
      else
         reg_rdata <= 32'h00000000;
   end

   // assertions
   sequence pend_enter_s;
      state == ST_ACT_TXRX && frame_sync_lost && !quiet;
   endsequence

   quiet_deact_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      quiet && state != ST_INACTIVE |=> state == ST_DEACT)
      else $error("quiet did not deactivate");
   inactive_quiet_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      state == ST_INACTIVE && line_signal_absent |=> state == ST_INACTIVE)
      else $error("inactive left without line signal");
   silent_tx_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      tx_slot.sym_en && state inside {ST_INACTIVE, ST_PRE_WAIT, ST_DEACT} |=> !tx_on)
      else $error("transmitter not silent");
   wake_levels_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      tx_slot.sym_en && state == ST_WAKEUP && tx_slot.kind != SLOT_SYNC
      |=> tx_level == LVL_P3 || tx_level == LVL_M3)
      else $error("wake-up level not three");
   stuff_run_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      stuff_run <= STUFF_RUN_MAX)
      else $error("stuffing run too long");
   sync_gain_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      frame_sync_lost && !hit_once && rx.frame_end |=> frame_sync_lost)
      else $error("sync declared on one hit");
   pend_enter_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      pend_enter_s |=> state == ST_PENDING ##0 sync_loss_timeout == $past(sync_loss_timeout))
      else $error("sync loss did not pend");
   ready_bit_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      state == ST_ACT_RX && !frame_sync_lost |-> !ready_bit)
      else $error("readiness bit not zero");
   rx_ones_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      rx.data_valid && state inside {ST_WAKEUP, ST_TRAINING, ST_ACT_TX} |=> rx_core_data == 2'h3)
      else $error("receive data not forced to ones");
   pre_wait_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      state == ST_PRE_WAIT && next_state == ST_WAKEUP |-> step_ms == PRE_WAIT_MS && !quiet)
      else $error("wake-up before pre-wait end");
endmodule : hra_remote_activation

// file: test/hra_central_model.sv
// Purpose: central unit model at the far end of the pair
// Assumes: one received frame every FRAME_CYC cycles while the line is on
// Notes:   released lines show a changing pattern, never the last value
`timescale 1ns/1ps
module hra_central_model
   import hra_pkg::*;
#(
   parameter int FRAME_CYC = 20
)(
   // clock
   input  wire logic ref_clk,
   // scenario controls
   input  wire logic line_on,
   input  wire logic four_on,
   input  wire logic sync_on,
   input  wire logic indc_val,
   // line toward the remote unit
   output logic      line_signal_absent_pin,
   output hra_rx_t   rx
);
   int cnt = 0;
   initial
   begin
      line_signal_absent_pin = 1'b1;
      rx = '0;
   end
   always @(posedge ref_clk)
   begin
      cnt <= (cnt == FRAME_CYC - 1) ? 0 : cnt + 1;
      line_signal_absent_pin <= !line_on;
      rx.frame_end <= line_on && cnt == FRAME_CYC - 1;
      rx.sync_hit <= line_on && sync_on && cnt == FRAME_CYC - 1;
      // valid readiness bit while on, else changing
      rx.indc_bit <= line_on ? indc_val : ~rx.indc_bit;
      // training switch held back by the bench
      rx.four_level <= line_on && four_on;
      rx.data_valid <= line_on && cnt[1:0] == 2'h0;
      rx.data <= line_on ? 2'h1 : ~rx.data;
   end
endmodule : hra_central_model

// file: test/hdsl_remote_activation_fsm_tb.sv
// Purpose: self-checking bench of the remote activation controller
// Assumes: TICK_CYC of 1, so one timer millisecond is one cycle
// Notes:   local framer slots come from a free-running generator
`timescale 1ns/1ps
module hdsl_remote_activation_fsm_tb
   import hra_pkg::*;
;
   logic         ref_clk = 1'b0;
   logic         sys_rst = 1'b1;
   logic [3:0]   reg_addr = 4'h0;
   logic [31:0]  reg_wdata = 32'h0;
   logic         reg_wr = 1'b0;
   logic         reg_rd = 1'b0;
   logic [31:0]  reg_rdata;
   logic         line_signal_absent_pin;
   hra_rx_t      rx;
   logic [1:0]   rx_core_data;
   hra_tx_slot_t tx_slot = '0;
   logic [1:0]   tx_core_data = 2'h0;
   logic [1:0]   tx_level;
   logic         tx_on;
   hra_state_t   state;
   logic         frame_sync_lost;
   logic         sync_loss_timeout;
   logic         line_on = 1'b0;
   logic         four_on = 1'b0;
   logic         sync_on = 1'b0;
   logic         indc_val = 1'b1;
   logic [3:0]   sym_pos = 4'h0;
   logic         stuff_d = 1'b0;
   logic [31:0]  d;
   int           n_mismatch = 0;
   int           n_tests = 0;
   int           n;
   int           sil;

   always #10 ref_clk = ~ref_clk;

   // framer: a symbol every other cycle, 16 symbols a frame
   always @(posedge ref_clk)
   begin
      tx_slot.sym_en <= ~tx_slot.sym_en;
      tx_slot.frame_start <= ~tx_slot.sym_en && sym_pos == 4'h0;
      tx_slot.kind <= sym_pos == 4'h0 ? SLOT_SYNC : sym_pos == 4'h1 ? SLOT_STUFF :
                      sym_pos == 4'h2 ? SLOT_OVHD : SLOT_PAYLOAD;
      tx_slot.ready_slot <= sym_pos == 4'h2;
      tx_slot.bits <= sym_pos[1:0];
      if (!tx_slot.sym_en)
         sym_pos <= sym_pos + 4'h1;
      stuff_d <= tx_slot.sym_en && tx_slot.kind == SLOT_STUFF;
      tx_core_data <= ~tx_core_data;
   end

   hra_remote_activation #(.TICK_CYC(1)) dut (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .line_signal_absent_pin(line_signal_absent_pin), .rx(rx), .rx_core_data(rx_core_data),
      .tx_slot(tx_slot), .tx_core_data(tx_core_data), .tx_level(tx_level), .tx_on(tx_on),
      .state(state), .frame_sync_lost(frame_sync_lost), .sync_loss_timeout(sync_loss_timeout));

   hra_central_model far_end (
      .ref_clk(ref_clk), .line_on(line_on), .four_on(four_on), .sync_on(sync_on),
      .indc_val(indc_val), .line_signal_absent_pin(line_signal_absent_pin), .rx(rx));

   task stop_test;
      if (n_mismatch == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : stop_test

   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
         n_mismatch++;
      end
   endtask : check

   task cyc(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask : cyc

   // waits for a state; counts cycles and cycles with the line driven
   task wait_state(input hra_state_t s, input int lim);
      n = 0;
      sil = 0;
      while (state !== s)
      begin
         cyc(1);
         n++;
         if (tx_on !== 1'b0)
            sil++;
         if (n > lim)
         begin
            n_mismatch++;
            stop_test();
         end
      end
   endtask : wait_state

   task wait_frames(input int k);
      int t;
      repeat (k)
      begin
         t = 0;
         do
         begin
            cyc(1);
            t++;
            if (t > 100)
            begin
               n_mismatch++;
               stop_test();
            end
         end
         while (rx.frame_end !== 1'b1);
      end
      cyc(3);
   endtask : wait_frames

   task reg_write(input logic [3:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : reg_write

   task reg_read(input logic [3:0] a);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : reg_read

   task s_reset;
      cyc(1);
      check(32'(state), 32'(ST_INACTIVE));
      check(32'(tx_on), 32'h0);
      check(32'(rx_core_data), 32'h3);
      reg_read(REG_STATUS);
      check(d, 32'h50);
      reg_read(4'h8);
      check(d, 32'h0);
      reg_read(REG_CTRL);
      check(d, 32'h0);
   endtask : s_reset

   task s_prewait;
      @(posedge ref_clk);
      line_on <= 1'b1;
      wait_state(ST_WAKEUP, 2200);
      check(32'(n >= 1900 && n <= 2100), 32'h1);
      check(32'(sil), 32'h0);
   endtask : s_prewait

   task s_wakeup;
      int bad;
      int run;
      logic [1:0] last;
      bad = 0;
      run = 0;
      last = 2'h1;
      cyc(4);
      repeat (5000)
      begin
         if (tx_on !== 1'b1 || (tx_level !== LVL_P3 && tx_level !== LVL_M3))
            bad++;
         if (stuff_d === 1'b1)
         begin
            run = (tx_level === last) ? run + 1 : 1;
            last = tx_level;
            if (run > 4)
               bad = bad + 1000;
         end
         cyc(1);
      end
      check(32'(bad), 32'h0);
      check(32'(state), 32'(ST_WAKEUP));
      check(32'(rx_core_data), 32'h3);
   endtask : s_wakeup

   task s_train;
      @(posedge ref_clk);
      four_on <= 1'b1;
      wait_frames(3);
      check(32'(frame_sync_lost), 32'h1);
      check(32'(state), 32'(ST_WAKEUP));
      sync_on <= 1'b1;
      wait_frames(1);
      check(32'(frame_sync_lost), 32'h1);
      wait_frames(1);
      check(32'(frame_sync_lost), 32'h0);
      wait_state(ST_ACT_RX, 10);
      sil = 0;
      repeat (64)
      begin
         cyc(1);
         if (tx_level[0] === 1'b1)
            sil++;
      end
      check(32'(sil > 0), 32'h1);
      check(32'(rx_core_data), 32'h1);
      reg_read(REG_STATUS);
      check(d & 32'h6ff, 32'h284);
   endtask : s_train

   task s_ready;
      @(posedge ref_clk);
      indc_val <= 1'b0;
      wait_frames(5);
      check(32'(state), 32'(ST_ACT_RX));
      wait_frames(1);
      check(32'(state), 32'(ST_ACT_TXRX));
   endtask : s_ready

   task s_loss;
      sync_on <= 1'b0;
      wait_frames(5);
      check(32'(frame_sync_lost), 32'h0);
      wait_frames(1);
      check(32'(frame_sync_lost), 32'h1);
      check(32'(state), 32'(ST_PENDING));
      sync_on <= 1'b1;
      wait_frames(2);
      check(32'(state), 32'(ST_ACT_TXRX));
      sync_on <= 1'b0;
      wait_frames(6);
      wait_state(ST_DEACT, 2200);
      check(32'(n >= 1800 && n <= 2100), 32'h1);
      check(32'(sync_loss_timeout), 32'h1);
      cyc(4);
      check(32'(tx_on), 32'h0);
      reg_write(REG_STATUS, 32'h20);
      reg_read(REG_STATUS);
      check(d & 32'h3f, 32'h18);
   endtask : s_loss

   task s_quiet_idle;
      line_on <= 1'b0;
      wait_state(ST_INACTIVE, 100);
      reg_write(REG_CTRL, 32'h1);
      cyc(50);
      check(32'(state), 32'(ST_INACTIVE));
      reg_read(REG_CTRL);
      check(d, 32'h1);
      reg_write(REG_CTRL, 32'h0);
   endtask : s_quiet_idle

   task s_expiry;
      four_on <= 1'b0;
      indc_val <= 1'b1;
      line_on <= 1'b1;
      wait_state(ST_WAKEUP, 2200);
      wait_state(ST_DEACT, 31200);
      check(32'(n >= 27000 && n <= 31000), 32'h1);
      cyc(4);
      check(32'(tx_on), 32'h0);
      check(32'(frame_sync_lost), 32'h1);
   endtask : s_expiry

   task s_quiet_active;
      line_on <= 1'b0;
      wait_state(ST_INACTIVE, 100);
      line_on <= 1'b1;
      wait_state(ST_WAKEUP, 2200);
      four_on <= 1'b1;
      sync_on <= 1'b1;
      wait_state(ST_ACT_RX, 300);
      indc_val <= 1'b0;
      wait_state(ST_ACT_TXRX, 300);
      reg_write(REG_CTRL, 32'h1);
      wait_state(ST_DEACT, 10);
      cyc(4);
      check(32'(tx_on), 32'h0);
      reg_write(REG_CTRL, 32'h0);
   endtask : s_quiet_active

   initial
   begin
      repeat (12) @(posedge ref_clk);
      sys_rst <= 1'b0;
      s_reset();
      s_prewait();
      s_wakeup();
      s_train();
      s_ready();
      s_loss();
      s_quiet_idle();
      s_expiry();
      s_quiet_active();
      stop_test();
   end
endmodule : hdsl_remote_activation_fsm_tb
